// ---- logic/ssdp_pkg.sv ----
/*
  Package for the serial status and data path block: register indices,
  field positions, reset values, link timing and the shifter state type.
  Assumes a 25 MHz system clock and an Avalon-MM host with 32-bit data.
*/
package ssdp_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [7:0] IDX_CTRL = 8'hba;  // Control
  localparam logic [7:0] IDX_STAT = 8'hbb;  // serial_status
  localparam logic [7:0] IDX_DATA = 8'hbc;  // transmit_shift / receive_buffer
  localparam logic [7:0] IDX_MASK = 8'hbd;  // Interrupt mask

  // Control bit positions
  localparam int CTL_IRQ_EN = 7;  // Interrupt gate
  localparam int CTL_ENABLE = 5;  // Interface enable
  localparam int CTL_ROLE   = 4;  // 1 controller, 0 target

  // Status bit positions
  localparam int ST_DONE  = 7;  // transfer_done_flag
  localparam int ST_WRITE_COLLISION_FLAG  = 6;  // write_collision_flag
  localparam int ST_FAULT = 4;  // multi_controller_fault_flag

  // Values after reset
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'hd0;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [3:0] SYNC_RST = 4'h8;  // Select line idles high

  // Link timing: half period of the generated serial clock
  localparam int CLK_NS       = 40;
  localparam int SCK_HALF_NS  = 160;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] HALF_LAST = 3'(SCK_HALF_CYC - 1);
  localparam logic [2:0] BIT_LAST  = 3'h7;

  // Shifter states
  typedef enum logic [1:0] {
    SSDP_IDLE  = 2'b00,
    SSDP_CLOW  = 2'b01,
    SSDP_CHIGH = 2'b10,
    SSDP_TGT   = 2'b11
  } ssdp_state_e;

endpackage

// ---- logic/ssdp_shifter.sv ----
/*
  Byte shifter for both roles, mode 0 (clock idles low, sample on rise).
  Assumes link pins are asynchronous; each passes two flip-flops first.
*/
`timescale 1ns/1ps
module ssdp_shifter (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       arst_n,
  // Control from the register side
  input  wire logic       load,
  input  wire logic [7:0] load_data,
  input  wire logic       enable,
  input  wire logic       role_ctrl,
  // Link inputs
  input  wire logic       sck_i,
  input  wire logic       mosi_i,
  input  wire logic       miso_i,
  input  wire logic       ss_n_i,
  // Status to the register side
  output logic            busy,
  output logic            done,
  output logic            fault,
  output logic [7:0]      shift_data,
  // Link outputs
  output logic            sck_o,
  output logic            sck_oe,
  output logic            mosi_o,
  output logic            mosi_oe,
  output logic            miso_o,
  output logic            miso_oe
);

  // Synchroniser stages: {ss_n, miso, mosi, sck}
  logic [3:0] pin_raw;
  logic [3:0] meta_reg;
  logic [3:0] sync_reg;
  assign pin_raw = {ss_n_i, miso_i, mosi_i, sck_i};

  // Two flip-flops per pin
  for (genvar g = 0; g < 4; g++)
  begin : g_sync
    always_ff @(posedge clk or negedge arst_n)
    begin
      if (!arst_n)
      begin
        meta_reg[g] <= ssdp_pkg::SYNC_RST[g];
        sync_reg[g] <= ssdp_pkg::SYNC_RST[g];
      end
      else
      begin
        meta_reg[g] <= pin_raw[g];
        sync_reg[g] <= meta_reg[g];
      end
    end
  end

  // Shifter state
  ssdp_pkg::ssdp_state_e st_reg, st_next;
  logic [7:0] shift_reg, shift_next;  // Shift register
  logic [2:0] cnt_reg, cnt_next;      // Bit counter
  logic [2:0] div_reg, div_next;      // Half period counter
  logic       bit_reg, bit_next;      // Sampled bit
  logic       sck_reg, sck_next;      // Generated clock
  logic       sckd_reg, sckd_next;    // Delayed synced clock
  logic       done_reg, done_next;
  logic       fault_reg, fault_next;
  logic       sck_oe_reg, sck_oe_next;
  logic       miso_oe_reg, miso_oe_next;
  logic       rise, fall, ss_act, abort;

  // Edges of the remote clock and select level
  assign rise   = sync_reg[0] & ~sckd_reg;
  assign fall   = ~sync_reg[0] & sckd_reg;
  assign ss_act = ~sync_reg[3];

  // Next state of the shifter
  always_comb
  begin
    st_next      = st_reg;
    shift_next   = shift_reg;
    cnt_next     = cnt_reg;
    div_next     = div_reg;
    bit_next     = bit_reg;
    sck_next     = sck_reg;
    sckd_next    = sync_reg[0];
    done_next    = 1'b0;
    // Select asserted while we drive as controller
    fault_next   = enable & role_ctrl & ss_act;
    sck_oe_next  = enable & role_ctrl;
    miso_oe_next = enable & ~role_ctrl & ss_act;
    abort        = fault_next | ~enable | ~role_ctrl;
    // Host byte goes straight into the shifter
    if (load)
      shift_next = load_data;
    case (st_reg)
      ssdp_pkg::SSDP_IDLE:
      begin
        // Controller starts on the write itself
        if (load && enable && role_ctrl && !ss_act)
        begin
          st_next  = ssdp_pkg::SSDP_CLOW;
          cnt_next = 3'h0;
          div_next = 3'h0;
        end
        else if (enable && !role_ctrl && ss_act)
        begin
          st_next  = ssdp_pkg::SSDP_TGT;
          cnt_next = 3'h0;
        end
      end
      ssdp_pkg::SSDP_CLOW:
      begin
        if (abort)
        begin
          st_next  = ssdp_pkg::SSDP_IDLE;
          sck_next = 1'b0;
        end
        else if (div_reg == ssdp_pkg::HALF_LAST)
        begin
          // Rising edge: sample the returning line
          div_next = 3'h0;
          sck_next = 1'b1;
          bit_next = sync_reg[2];
          st_next  = ssdp_pkg::SSDP_CHIGH;
        end
        else
          div_next = div_reg + 3'h1;
      end
      ssdp_pkg::SSDP_CHIGH:
      begin
        if (abort)
        begin
          st_next  = ssdp_pkg::SSDP_IDLE;
          sck_next = 1'b0;
        end
        else if (div_reg == ssdp_pkg::HALF_LAST)
        begin
          // Falling edge: shift, count, finish after eight
          div_next   = 3'h0;
          sck_next   = 1'b0;
          shift_next = {shift_reg[6:0], bit_reg};
          cnt_next   = cnt_reg + 3'h1;
          if (cnt_reg == ssdp_pkg::BIT_LAST)
          begin
            done_next = 1'b1;
            st_next   = ssdp_pkg::SSDP_IDLE;
          end
          else
            st_next = ssdp_pkg::SSDP_CLOW;
        end
        else
          div_next = div_reg + 3'h1;
      end
      default:
      begin
        // Target: remote controller clocks us while selected
        if (!ss_act || !enable || role_ctrl)
          st_next = ssdp_pkg::SSDP_IDLE;
        else
        begin
          if (rise)
            bit_next = sync_reg[1];
          if (fall)
          begin
            shift_next = {shift_reg[6:0], bit_reg};
            cnt_next   = cnt_reg + 3'h1;
            if (cnt_reg == ssdp_pkg::BIT_LAST)
              done_next = 1'b1;
          end
        end
      end
    endcase
  end

  // Register the shifter state
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_reg      <= ssdp_pkg::SSDP_IDLE;
      shift_reg   <= ssdp_pkg::DATA_RST;
      cnt_reg     <= 3'h0;
      div_reg     <= 3'h0;
      bit_reg     <= 1'b0;
      sck_reg     <= 1'b0;
      sckd_reg    <= 1'b0;
      done_reg    <= 1'b0;
      fault_reg   <= 1'b0;
      sck_oe_reg  <= 1'b0;
      miso_oe_reg <= 1'b0;
    end
    else
    begin
      st_reg      <= st_next;
      shift_reg   <= shift_next;
      cnt_reg     <= cnt_next;
      div_reg     <= div_next;
      bit_reg     <= bit_next;
      sck_reg     <= sck_next;
      sckd_reg    <= sckd_next;
      done_reg    <= done_next;
      fault_reg   <= fault_next;
      sck_oe_reg  <= sck_oe_next;
      miso_oe_reg <= miso_oe_next;
    end
  end

  // Outputs, all from flip-flops
  assign busy       = (st_reg != ssdp_pkg::SSDP_IDLE);
  assign done       = done_reg;
  assign fault      = fault_reg;
  assign shift_data = shift_reg;
  assign sck_o      = sck_reg;
  assign sck_oe     = sck_oe_reg;
  assign mosi_o     = shift_reg[7];
  assign mosi_oe    = sck_oe_reg;
  assign miso_o     = shift_reg[7];
  assign miso_oe    = miso_oe_reg;

endmodule

// ---- logic/ssdp_top.sv ----
/*
  Serial status and data path: Avalon-MM register slave, sticky flags,
  interrupt, receive buffer and the byte shifter for either role.
  Assumes a host master that holds its request until waitrequest is low.
*/
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
// Behaviour
// - Byte done sets status bit 7, interrupts
// - Status read clears done flag
// - Collision sets bit 6, read clears
// - Controller conflict sets bit 4, read clears
// - Data write loads shifter directly
// - Controller write starts transfer at once
// - Done flag set in both roles
// - Write and read share the data address
// - Read returns received byte
// - Overrun drops new byte, keeps old
// - Write while busy is a collision
// - Control bit selects controller or target
// - Control bit gates the interrupt
module ssdp_top (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Avalon-MM slave
  input  wire logic [9:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Interrupt
  output logic             irq,
  // Serial link
  input  wire logic        sck_i,
  output logic             sck_o,
  output logic             sck_oe,
  input  wire logic        mosi_i,
  output logic             mosi_o,
  output logic             mosi_oe,
  input  wire logic        miso_i,
  output logic             miso_o,
  output logic             miso_oe,
  input  wire logic        ss_n_i
);

  // Register state
  logic [7:0]  ctrl_reg, ctrl_next;    // Control
  logic [7:0]  stat_reg, stat_next;    // Sticky flags
  logic [7:0]  mask_reg, mask_next;    // Interrupt mask
  logic [7:0]  rxb_reg, rxb_next;      // Receive buffer
  logic        wait_reg, wait_next;    // Waitrequest
  logic [31:0] rdata_reg, rdata_next;  // Read data
  logic        irq_reg, irq_next;

  // Decode and event terms
  logic [7:0] idx;         // Register index
  logic [7:0] rd_val;      // Selected read value
  logic [7:0] clr;         // Bits cleared by a status read
  logic       accept;      // First cycle of a request
  logic       commit;      // Answer edge
  logic       wr_ok;       // Write takes effect
  logic       wr_data;     // Write to the data address
  logic       load;        // Shifter load
  logic       write_collision_flag_ev;     // Collision event
  logic       overrun;     // Byte done while flag still set
  logic       shf_busy;
  logic       shf_done;
  logic       shf_fault;
  logic [7:0] shf_data;

  assign idx    = avs_address[9:2];
  assign accept = (avs_read | avs_write) & wait_reg;
  assign commit = (avs_read | avs_write) & ~wait_reg;
  assign wr_ok  = commit & avs_write & avs_byteenable[0];

  // Read multiplexer
  always_comb
  begin
    if (idx == ssdp_pkg::IDX_CTRL)
      rd_val = ctrl_reg;
    else if (idx == ssdp_pkg::IDX_STAT)
      rd_val = stat_reg;
    else if (idx == ssdp_pkg::IDX_DATA)
      rd_val = rxb_reg;
    else if (idx == ssdp_pkg::IDX_MASK)
      rd_val = mask_reg;
    else
      rd_val = 8'h00;
  end

  // Event terms from the bus and the shifter
  always_comb
  begin
    wr_data = wr_ok & (idx == ssdp_pkg::IDX_DATA);
    load    = wr_data & ~shf_busy;
    write_collision_flag_ev = wr_data & shf_busy;
    // Only bits the host actually saw are cleared
    if (commit && avs_read && idx == ssdp_pkg::IDX_STAT)
      clr = rdata_reg[7:0];
    else
      clr = 8'h00;
    // Host failed to clear in time
    overrun = shf_done & stat_reg[ssdp_pkg::ST_DONE] & ~clr[ssdp_pkg::ST_DONE];
  end

  // Next register values; a set wins over a clear
  always_comb
  begin
    ctrl_next  = ctrl_reg;
    mask_next  = mask_reg;
    stat_next  = stat_reg & ~clr;
    rxb_next   = rxb_reg;
    wait_next  = ~accept;
    rdata_next = rdata_reg;
    if (shf_done)
      stat_next[ssdp_pkg::ST_DONE] = 1'b1;
    if (write_collision_flag_ev)
      stat_next[ssdp_pkg::ST_WRITE_COLLISION_FLAG] = 1'b1;
    if (shf_fault)
      stat_next[ssdp_pkg::ST_FAULT] = 1'b1;
    // Copy on completion unless the byte overran
    if (shf_done && !overrun)
      rxb_next = shf_data;
    if (wr_ok && idx == ssdp_pkg::IDX_CTRL)
      ctrl_next = avs_writedata[7:0];
    else if (wr_ok && idx == ssdp_pkg::IDX_MASK)
      mask_next = avs_writedata[7:0];
    if (accept && avs_read)
      rdata_next = {24'h00_0000, rd_val};
    // Interrupt gated by the control bit
    irq_next = ctrl_reg[ssdp_pkg::CTL_IRQ_EN] & (|(stat_reg & mask_reg));
  end

  // Register all bus-side state
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctrl_reg  <= ssdp_pkg::CTRL_RST;
      stat_reg  <= ssdp_pkg::STAT_RST;
      mask_reg  <= ssdp_pkg::MASK_RST;
      rxb_reg   <= ssdp_pkg::DATA_RST;
      wait_reg  <= 1'b1;
      rdata_reg <= 32'h0000_0000;
      irq_reg   <= 1'b0;
    end
    else
    begin
      ctrl_reg  <= ctrl_next;
      stat_reg  <= stat_next;
      mask_reg  <= mask_next;
      rxb_reg   <= rxb_next;
      wait_reg  <= wait_next;
      rdata_reg <= rdata_next;
      irq_reg   <= irq_next;
    end
  end

  assign avs_readdata    = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign irq             = irq_reg;

  // Byte shifter
  ssdp_shifter u_shifter (
    .clk        (clk),
    .arst_n     (arst_n),
    .load       (load),
    .load_data  (avs_writedata[7:0]),
    .enable     (ctrl_reg[ssdp_pkg::CTL_ENABLE]),
    .role_ctrl  (ctrl_reg[ssdp_pkg::CTL_ROLE]),
    .sck_i      (sck_i),
    .mosi_i     (mosi_i),
    .miso_i     (miso_i),
    .ss_n_i     (ss_n_i),
    .busy       (shf_busy),
    .done       (shf_done),
    .fault      (shf_fault),
    .shift_data (shf_data),
    .sck_o      (sck_o),
    .sck_oe     (sck_oe),
    .mosi_o     (mosi_o),
    .mosi_oe    (mosi_oe),
    .miso_o     (miso_o),
    .miso_oe    (miso_oe)
  );

  // Checks on the flag, buffer and bus behaviour
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  property p_done_set;
    shf_done |=> stat_reg[ssdp_pkg::ST_DONE];
  endproperty
  a_done_set: assert property (p_done_set) else $error("done flag not set");

  property p_done_clr;
    (clr[ssdp_pkg::ST_DONE] && !shf_done) |=> !stat_reg[ssdp_pkg::ST_DONE];
  endproperty
  a_done_clr: assert property (p_done_clr) else $error("done flag not cleared");

  property p_write_collision_flag;
    // The running byte may shift by one place, but is never replaced
    (wr_data && shf_busy) |=> stat_reg[ssdp_pkg::ST_WRITE_COLLISION_FLAG]
      && (shf_data == $past(shf_data) || shf_data[7:1] == $past(shf_data[6:0]));
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision not flagged");

  property p_write_collision_flag_cause;
    $rose(stat_reg[ssdp_pkg::ST_WRITE_COLLISION_FLAG]) |-> $past(write_collision_flag_ev);
  endproperty
  a_write_collision_flag_cause: assert property (p_write_collision_flag_cause) else $error("collision without cause");

  property p_fault;
    shf_fault |=> stat_reg[ssdp_pkg::ST_FAULT] && !shf_busy;
  endproperty
  a_fault: assert property (p_fault) else $error("fault not flagged");

  property p_load;
    load |=> shf_data == $past(avs_writedata[7:0]);
  endproperty
  a_load: assert property (p_load) else $error("byte not loaded");

  property p_start;
    (load && ctrl_reg[ssdp_pkg::CTL_ROLE] && ctrl_reg[ssdp_pkg::CTL_ENABLE] && !shf_fault)
      |=> shf_busy ##[3:6] sck_o;
  endproperty
  a_start: assert property (p_start) else $error("controller did not start");

  property p_role;
    (ctrl_reg[ssdp_pkg::CTL_ROLE] && ctrl_reg[ssdp_pkg::CTL_ENABLE]) [*2] |-> sck_oe && !miso_oe;
  endproperty
  a_role: assert property (p_role) else $error("role not followed");

  property p_copy;
    (shf_done && !overrun) |=> rxb_reg == $past(shf_data);
  endproperty
  a_copy: assert property (p_copy) else $error("buffer not copied");

  property p_overrun;
    overrun |=> $stable(rxb_reg) && stat_reg[ssdp_pkg::ST_DONE];
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun byte kept");

  property p_data_read;
    (accept && avs_read && idx == ssdp_pkg::IDX_DATA) |=> avs_readdata[7:0] == $past(rxb_reg);
  endproperty
  a_data_read: assert property (p_data_read) else $error("wrong read data");

  property p_irq_gate;
    !ctrl_reg[ssdp_pkg::CTL_IRQ_EN] |=> !irq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt not gated");

  property p_answer;
    accept |=> !avs_waitrequest ##1 avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("bus answer late");

  c_done: cover property (shf_done && !overrun);
  c_overrun: cover property (overrun);
  c_write_collision_flag: cover property (write_collision_flag_ev);
  c_irq: cover property ($rose(irq));

endmodule

// ---- tb/ssdp_partner.sv ----
/*
  Far-side model of the serial link: a mode 0 peripheral while the block
  is controller, and a controller that frames bytes while it is target.
  Assumes the bench resolves each link line and feeds the result back.
*/
`timescale 1ns/1ps
module ssdp_partner (
  // Resolved link lines
  input  wire logic sck_line,
  input  wire logic mosi_line,
  input  wire logic miso_line,
  // Lines this model drives
  output logic      p_sck,
  output logic      p_mosi,
  output logic      p_miso,
  output logic      p_ss_n
);
  logic [7:0] tx_sr;    // Outgoing byte, msb first
  logic [7:0] rx_sr;    // Incoming bits
  logic [7:0] last_rx;  // Last whole byte received
  logic       act;      // Model is the controller
  int         bits;     // Bits of the current byte
  int         bytes;    // Whole bytes received

  // Idle link: clock stands low, select high
  initial
  begin
    p_sck = 1'b0;
    p_ss_n = 1'b1;
    act = 1'b0;
    tx_sr = 8'h00;
    rx_sr = 8'h00;
    last_rx = 8'h00;
    bits = 0;
    bytes = 0;
  end

  // Both data lines carry the outgoing msb
  assign p_mosi = tx_sr[7];
  assign p_miso = tx_sr[7];

  // Sample on the rising serial clock
  always @(posedge sck_line)
  begin
    rx_sr = {rx_sr[6:0], act ? miso_line : mosi_line};
    bits++;
    if (bits == 8)
    begin
      last_rx = rx_sr;
      bytes++;
      bits = 0;
    end
  end

  // Shift on the falling clock; the filler bit keeps the line moving
  always @(negedge sck_line)
    tx_sr = {tx_sr[6:0], ~tx_sr[0]};

  // Preload the next outgoing byte
  task automatic load(input logic [7:0] b);
    tx_sr = b;
    bits = 0;
  endtask

  // Drive select directly, for the conflict case
  task automatic select(input logic v);
    p_ss_n = v;
  endtask

  // One controller frame of eight bits at 320 ns per bit
  task automatic frame(input logic [7:0] b);
    #7;
    act = 1'b1;
    load(b);
    p_ss_n = 1'b0;
    #400;
    repeat (8)
    begin
      p_sck = 1'b1;
      #160;
      p_sck = 1'b0;
      #160;
    end
    #200;
    p_ss_n = 1'b1;
    act = 1'b0;
  endtask
endmodule

// ---- tb/ssdp_top_tb.sv ----
/*
  Self-checking bench for the serial status and data path block.
  Assumes the Avalon-MM answer comes within a bounded number of cycles.
*/
`timescale 1ns/1ps
module ssdp_top_tb;
  logic        clk;             // System clock
  logic        arst_n;          // Reset, active low
  logic [9:0]  avs_address;     // Byte address
  logic        avs_read;        // Read request
  logic        avs_write;       // Write request
  logic [31:0] avs_writedata;   // Write data
  logic [3:0]  avs_byteenable;  // Byte lanes
  logic [31:0] avs_readdata;    // Read data
  logic        avs_waitrequest; // Slave stall
  logic        irq;             // Interrupt
  logic        sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  logic        p_sck, p_mosi, p_miso, p_ss_n;
  logic        sck_line, mosi_line, miso_line;
  logic [31:0] seed;            // Random state
  logic [7:0]  d;               // Read result
  logic [7:0]  tx;              // Byte sent by the block
  logic [7:0]  rb;              // Byte sent by the far side
  int          fails;
  int          comparisons;

  // Each line follows whoever enables it
  assign sck_line  = sck_oe  ? sck_o  : p_sck;
  assign mosi_line = mosi_oe ? mosi_o : p_mosi;
  assign miso_line = miso_oe ? miso_o : p_miso;

  // Block under test
  ssdp_top u_ssdp_top (.clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .sck_i(sck_line),
    .sck_o(sck_o), .sck_oe(sck_oe), .mosi_i(mosi_line), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
    .miso_i(miso_line), .miso_o(miso_o), .miso_oe(miso_oe), .ss_n_i(p_ss_n));

  // Far side
  ssdp_partner u_ssdp_partner (.sck_line(sck_line), .mosi_line(mosi_line), .miso_line(miso_line),
    .p_sck(p_sck), .p_mosi(p_mosi), .p_miso(p_miso), .p_ss_n(p_ss_n));

  // 25 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Next random state
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task automatic print_verdict;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // One Avalon-MM cycle, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
    int n;
    @(posedge clk);
    avs_address <= {idx, 2'b00};
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= {24'h00_0000, wd};
    n = 0;
    // Waitrequest and read data are taken at the same rising edge
    do
    begin
      @(posedge clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 100);
    if (n >= 100)
      fails++;
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  // Controller byte: far side preloaded, then wait past the last fall
  task automatic xfer(input logic [7:0] t, input logic [7:0] r);
    int n;
    int goal;
    u_ssdp_partner.load(r);
    goal = u_ssdp_partner.bytes + 1;
    bus(1'b1, ssdp_pkg::IDX_DATA, t, d);
    n = 0;
    while (u_ssdp_partner.bytes < goal && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
    if (n >= 2000)
      fails++;
    repeat (8) @(posedge clk);
  endtask

  // Watchdog
  initial
  begin
    #800000;
    fails++;
    print_verdict();
  end

  // Main sequence
  initial
  begin
    {avs_address, avs_read, avs_write, avs_writedata} = '0;
    avs_byteenable = 4'hf;
    seed = 32'h0000_c9e0;
    fails = 0;
    comparisons = 0;
    arst_n = 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    // Reset values, mask access, unmapped place
    bus(1'b0, ssdp_pkg::IDX_STAT, 8'h00, d); check(d, ssdp_pkg::STAT_RST);
    bus(1'b0, ssdp_pkg::IDX_CTRL, 8'h00, d); check(d, ssdp_pkg::CTRL_RST);
    bus(1'b0, ssdp_pkg::IDX_MASK, 8'h00, d); check(d, ssdp_pkg::MASK_RST);
    bus(1'b0, 8'h10, 8'h00, d); check(d, 8'h00);
    // A write with lane 0 disabled is answered but has no effect
    avs_byteenable <= 4'he;
    bus(1'b1, ssdp_pkg::IDX_CTRL, 8'h30, d);
    avs_byteenable <= 4'hf;
    bus(1'b0, ssdp_pkg::IDX_CTRL, 8'h00, d); check(d, ssdp_pkg::CTRL_RST);
    $display("test reset done");
    // Controller transfers, 8'hff/8'h00 first then random bytes, interrupt gated off
    bus(1'b1, ssdp_pkg::IDX_CTRL, 8'h30, d);
    for (int i = 0; i < 4; i++)
    begin
      seed = lfsr(seed);
      tx = (i == 0) ? 8'hff : seed[7:0];
      rb = (i == 0) ? 8'h00 : seed[15:8];
      xfer(tx, rb);
      check(irq, 1'b0);
      check(u_ssdp_partner.last_rx, tx);
      bus(1'b0, ssdp_pkg::IDX_STAT, 8'h00, d); check(d, 8'h80);
      bus(1'b0, ssdp_pkg::IDX_DATA, 8'h00, d); check(d, rb);
      bus(1'b0, ssdp_pkg::IDX_STAT, 8'h00, d); check(d, 8'h00);
    end
    $display("test controller done");
    // Write while busy is a collision and is dropped
    seed = lfsr(seed);
    u_ssdp_partner.load(8'h5a);
    bus(1'b1, ssdp_pkg::IDX_DATA, seed[7:0], d);
    xfer(~seed[7:0], 8'h5a);
    check(u_ssdp_partner.last_rx, seed[7:0]);
    bus(1'b0, ssdp_pkg::IDX_STAT, 8'h00, d); check(d, 8'hc0);
    bus(1'b0, ssdp_pkg::IDX_DATA, 8'h00, d); check(d, 8'h5a);
    bus(1'b0, ssdp_pkg::IDX_STAT, 8'h00, d); check(d, 8'h00);
    $display("test collision done");
    // Interrupt enabled, then masked
    bus(1'b1, ssdp_pkg::IDX_CTRL, 8'hb0, d);
    xfer(8'h3c, 8'hc3);
    check(irq, 1'b1);
    bus(1'b0, ssdp_pkg::IDX_STAT, 8'h00, d);
    repeat (2) @(posedge clk);
    check(irq, 1'b0);
    bus(1'b1, ssdp_pkg::IDX_MASK, 8'h00, d);
    xfer(8'h81, 8'h18);
    check(irq, 1'b0);
    bus(1'b0, ssdp_pkg::IDX_STAT, 8'h00, d); check(d, 8'h80);
    bus(1'b1, ssdp_pkg::IDX_MASK, 8'hd0, d);
    $display("test interrupt done");
    // Select pulled low against an enabled controller
    bus(1'b1, ssdp_pkg::IDX_CTRL, 8'h30, d);
    u_ssdp_partner.select(1'b0);
    repeat (8) @(posedge clk);
    u_ssdp_partner.select(1'b1);
    repeat (8) @(posedge clk);
    bus(1'b0, ssdp_pkg::IDX_STAT, 8'h00, d); check(d, 8'h10);
    bus(1'b0, ssdp_pkg::IDX_STAT, 8'h00, d); check(d, 8'h00);
    $display("test fault done");
    // Target role, then overrun
    bus(1'b1, ssdp_pkg::IDX_CTRL, 8'h20, d);
    seed = lfsr(seed);
    bus(1'b1, ssdp_pkg::IDX_DATA, seed[7:0], d);
    u_ssdp_partner.frame(seed[15:8]);
    repeat (6) @(posedge clk);
    check(u_ssdp_partner.last_rx, seed[7:0]);
    bus(1'b0, ssdp_pkg::IDX_STAT, 8'h00, d); check(d, 8'h80);
    bus(1'b0, ssdp_pkg::IDX_DATA, 8'h00, d); check(d, seed[15:8]);
    u_ssdp_partner.frame(seed[23:16]);
    u_ssdp_partner.frame(seed[31:24]);
    repeat (6) @(posedge clk);
    bus(1'b0, ssdp_pkg::IDX_DATA, 8'h00, d); check(d, seed[23:16]);
    bus(1'b0, ssdp_pkg::IDX_STAT, 8'h00, d); check(d, 8'h80);
    $display("test target done");
    print_verdict();
  end
endmodule
